// [src/psrpc_pkg.sv]
// package: register map, fields, reset values and timing for the reset controller
package psrpc_pkg;
	localparam logic [15:0] CORE_CONTROL_ADDR     = 16'h0000;
	localparam logic [15:0] SUBSYS_RESET_ADDR     = 16'hFF0C;
	localparam logic [15:0] PIN_RELATCH_EN_ADDR   = 16'hFF0D;
	localparam int          CORE_RESET_BIT        = 15;
	localparam int          SOFT_PD_BIT           = 11;
	localparam int          SUBSYS_RESET_BIT      = 0;
	localparam int          PIN_RELATCH_EN_BIT    = 0;
	localparam logic [15:0] CORE_CONTROL_RST      = 16'h0000;
	localparam logic        PIN_RELATCH_EN_RST    = 1'b0;
	localparam int          STRAP_W               = 8;
	localparam int          CLK_MHZ               = 40;
	localparam int          SEQ_STEP_NS           = 200;
	localparam int          SEQ_STEP_CYC          = (SEQ_STEP_NS * CLK_MHZ + 999) / 1000;
	localparam int          SETTLE_US             = 1000;
	localparam int          SETTLE_CYC            = SETTLE_US * CLK_MHZ;
	localparam int          DIV25_NUM             = 5;
	localparam int          DIV25_DEN             = 8;
	typedef enum logic [2:0] {
		PSRPC_RUN    = 3'b000,
		PSRPC_SETTLE = 3'b001,
		PSRPC_LATCH  = 3'b011,
		PSRPC_HOLD   = 3'b010,
		PSRPC_DONE   = 3'b110
	} psrpc_state_e;
	typedef enum logic [1:0] {
		PSRPC_KIND_HW   = 2'b00,
		PSRPC_KIND_PIN  = 2'b01,
		PSRPC_KIND_SUB  = 2'b11,
		PSRPC_KIND_CORE = 2'b10
	} psrpc_kind_e;
endpackage

// [src/psrpc_tick_if.sv]
// interface: enable pulse carried from the rate divider to the controller
`timescale 1ns/1ps
interface psrpc_tick_if;
	logic tick;
	modport src (output tick);
	modport dst (input tick);
endinterface

// [src/psrpc_divider.sv]
// fractional rate divider making a one-cycle enable pulse
`timescale 1ns/1ps
module psrpc_divider #(
	parameter int NUM = psrpc_pkg::DIV25_NUM,
	parameter int DEN = psrpc_pkg::DIV25_DEN
) (
	input  wire logic   ref_clk,
	input  wire logic   srst,
	input  wire logic   run,
	psrpc_tick_if.src   t
);
	import psrpc_pkg::*;
	initial begin
		if (NUM < 1 || NUM > DEN || DEN > 255)
			$error("bad divider ratio");
	end
	logic [8:0] acc;
	logic [8:0] sum;
	assign sum = acc + 9'(NUM);
	always_ff @(posedge ref_clk) begin
		if (srst || !run) begin
			acc    <= 9'h000;
			t.tick <= 1'b0;
		end else if (sum >= 9'(DEN)) begin
			acc    <= sum - 9'(DEN);
			t.tick <= 1'b1;
		end else begin
			acc    <= sum;
			t.tick <= 1'b0;
		end
	end
endmodule // psrpc_divider

// [src/psrpc_ctrl.sv]
// reset and power-down controller: reset types, domain resets, power modes
// Operation
// - re-latch reset runs hardware sequence but skips oscillator settling
// - re-latch reset samples straps again and resets MAC block and core
// - multiplier kept out of reset if 125 MHz aux clock chosen
// - re-latch enable bit returns to zero during its own reset
// - 125 MHz aux clock withheld while re-latch reset runs
// - subsystem reset bit resets all register domains, MAC block, core
// - plain subsystem reset reuses earlier latched strap values
// - aux clock keeps running during plain subsystem or core resets
// - core reset bit resets core registers and core, not MAC block
// - core reset keeps subsystem registers, restores core strap defaults
// - reset pin low means full power-down, registers not accessible
// - hardware power-down tristates MAC outputs and stops aux clock
// - soft power-down bit forces soft power-down, default from straps
// - soft power-down ignores line, keeps registers, clocks at 25 MHz
// - soft power-down drives MAC outputs low, receive clock high
// - multiplier stays enabled in soft power-down if 125 MHz chosen
// - clearing soft power-down starts link bring-up
`timescale 1ns/1ps
module psrpc_ctrl #(
	parameter int SETTLE_CYCLES = psrpc_pkg::SETTLE_CYC,
	parameter int STEP_CYCLES   = psrpc_pkg::SEQ_STEP_CYC,
	parameter int PD_STRAP_BIT  = 0
) (
	input  wire logic                           ref_clk,
	input  wire logic                           srst,
	input  wire logic                           reset_n_pin,
	input  wire logic [psrpc_pkg::STRAP_W-1:0]  strap_pins,
	input  wire logic                           link_state_strap_pin,
	input  wire logic                           indicator_strap_pin,
	input  wire logic                           aux_sel_125,
	input  wire logic                           aux_clock_enable,
	input  wire logic                           reg_wr,
	input  wire logic                           reg_rd,
	input  wire logic [15:0]                    reg_addr,
	input  wire logic [15:0]                    reg_wdata,
	output logic      [15:0]                    reg_rdata,
	output logic                                reg_ack,
	output logic      [psrpc_pkg::STRAP_W-1:0]  strap_latched,
	output logic                                xtal_enable,
	output logic                                subsys_regs_rst,
	output logic                                core_regs_rst,
	output logic                                mac_if_rst,
	output logic                                core_rst,
	output logic                                clock_multiplier_rst,
	output logic                                clock_multiplier_en,
	output logic                                aux_clock_out_en,
	output logic                                mac_out_oe_n,
	output logic                                mac_idle_force,
	output logic                                line_enable,
	output logic                                link_bringup,
	output logic                                slow_clk_en,
	output logic                                soft_powerdown
);
	import psrpc_pkg::*;
	initial begin
		if (SETTLE_CYCLES < 1 || STEP_CYCLES < 1 || PD_STRAP_BIT >= STRAP_W)
			$error("bad controller parameters");
	end
	psrpc_state_e state;
	psrpc_kind_e  kind;
	logic [31:0]  cnt;
	logic         pin_relatch_reset_enable;
	logic         subsystem_reset_trigger;
	logic         core_reset_trigger;
	logic         pd_default;
	logic         hw_pd;
	logic         busy;
	logic         acc_ok;
	logic         wr_sub;
	logic         wr_core;
	logic         pd_q;
	logic         pd_latched;
	psrpc_tick_if tk ();
	assign hw_pd   = !reset_n_pin;
	assign busy    = state != PSRPC_RUN;
	assign acc_ok  = !hw_pd && !busy;
	assign wr_sub  = acc_ok && reg_wr && reg_addr == SUBSYS_RESET_ADDR;
	assign wr_core = acc_ok && reg_wr && reg_addr == CORE_CONTROL_ADDR;
	assign pd_default = link_state_strap_pin & indicator_strap_pin;
	psrpc_divider u_div (
		.ref_clk (ref_clk),
		.srst    (srst),
		.run     (soft_powerdown && !hw_pd),
		.t       (tk)
	);
	always_ff @(posedge ref_clk) begin
		if (srst || hw_pd) begin
			state <= PSRPC_SETTLE;
			kind  <= PSRPC_KIND_HW;
			cnt   <= 32'h0;
		end else begin
			unique case (state)
			PSRPC_RUN: begin
				cnt <= 32'h0;
				if (wr_sub && reg_wdata[SUBSYS_RESET_BIT]) begin
					state <= pin_relatch_reset_enable ? PSRPC_LATCH
						: PSRPC_HOLD;
					kind  <= pin_relatch_reset_enable ? PSRPC_KIND_PIN
						: PSRPC_KIND_SUB;
				end else if (wr_core && reg_wdata[CORE_RESET_BIT]) begin
					state <= PSRPC_HOLD;
					kind  <= PSRPC_KIND_CORE;
				end
			end
			PSRPC_SETTLE: begin
				cnt <= cnt + 32'h1;
				if (cnt >= 32'(SETTLE_CYCLES - 1)) begin
					state <= PSRPC_LATCH;
					cnt   <= 32'h0;
				end
			end
			PSRPC_LATCH: state <= PSRPC_HOLD;
			PSRPC_HOLD: begin
				cnt <= cnt + 32'h1;
				if (cnt >= 32'(STEP_CYCLES - 1))
					state <= PSRPC_DONE;
			end
			PSRPC_DONE: state <= PSRPC_RUN;
			// unused code: finish so the trigger bits clear
			default: state <= PSRPC_DONE;
			endcase
		end
	end
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			strap_latched <= '0;
			pd_latched    <= 1'b0;
		end else if (!hw_pd && state == PSRPC_LATCH) begin
			strap_latched <= strap_pins;
			// link pins kept too, so later resets need no resample
			pd_latched    <= pd_default | strap_pins[PD_STRAP_BIT];
		end
	end
	always_ff @(posedge ref_clk) begin
		if (srst || hw_pd) begin
			pin_relatch_reset_enable <= PIN_RELATCH_EN_RST;
		end else if (state == PSRPC_LATCH && kind == PSRPC_KIND_PIN) begin
			pin_relatch_reset_enable <= PIN_RELATCH_EN_RST;
		end else if (acc_ok && reg_wr && reg_addr == PIN_RELATCH_EN_ADDR) begin
			pin_relatch_reset_enable <= reg_wdata[PIN_RELATCH_EN_BIT];
		end
	end
	// trigger bits hold 1 while their sequence runs, 0 once it is done
	always_ff @(posedge ref_clk) begin
		if (srst || hw_pd) begin
			subsystem_reset_trigger <= 1'b0;
			core_reset_trigger      <= 1'b0;
		end else if (state == PSRPC_DONE) begin
			subsystem_reset_trigger <= 1'b0;
			core_reset_trigger      <= 1'b0;
		end else begin
			if (wr_sub && reg_wdata[SUBSYS_RESET_BIT])
				subsystem_reset_trigger <= 1'b1;
			if (wr_core && reg_wdata[CORE_RESET_BIT])
				core_reset_trigger <= 1'b1;
		end
	end
	// power-down default restored from the straps on every core reset
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			soft_powerdown <= CORE_CONTROL_RST[SOFT_PD_BIT];
		end else if (hw_pd) begin
			soft_powerdown <= soft_powerdown;
		end else if (state == PSRPC_LATCH && kind != PSRPC_KIND_SUB
				&& kind != PSRPC_KIND_CORE) begin
			soft_powerdown <= pd_default | strap_pins[PD_STRAP_BIT];
		end else if (state == PSRPC_HOLD && kind != PSRPC_KIND_PIN
				&& kind != PSRPC_KIND_HW) begin
			soft_powerdown <= pd_latched;
		end else if (wr_core && !reg_wdata[CORE_RESET_BIT]) begin
			soft_powerdown <= reg_wdata[SOFT_PD_BIT];
		end
	end
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			reg_rdata <= 16'h0000;
			reg_ack   <= 1'b0;
		end else begin
			reg_ack   <= acc_ok && (reg_rd || reg_wr);
			reg_rdata <= 16'h0000;
			if (acc_ok && reg_rd) begin
				unique case (reg_addr)
				CORE_CONTROL_ADDR: begin
					reg_rdata[CORE_RESET_BIT] <= core_reset_trigger;
					reg_rdata[SOFT_PD_BIT]    <= soft_powerdown;
				end
				SUBSYS_RESET_ADDR:
					reg_rdata[SUBSYS_RESET_BIT] <= subsystem_reset_trigger;
				PIN_RELATCH_EN_ADDR:
					reg_rdata[PIN_RELATCH_EN_BIT] <= pin_relatch_reset_enable;
				default: reg_rdata <= 16'h0000;
				endcase
			end
		end
	end
	// domain resets come from flops so no glitch reaches the domains
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			xtal_enable          <= 1'b0;
			subsys_regs_rst      <= 1'b1;
			core_regs_rst        <= 1'b1;
			mac_if_rst           <= 1'b1;
			core_rst             <= 1'b1;
			clock_multiplier_rst <= 1'b1;
		end else begin
			xtal_enable     <= !hw_pd;
			subsys_regs_rst <= hw_pd || (busy && kind != PSRPC_KIND_CORE
				&& state != PSRPC_DONE);
			core_regs_rst   <= hw_pd || (busy && state != PSRPC_DONE);
			mac_if_rst      <= hw_pd || (busy && kind != PSRPC_KIND_CORE
				&& state != PSRPC_DONE);
			core_rst        <= hw_pd || (busy && state != PSRPC_DONE);
			clock_multiplier_rst <= hw_pd || (busy && state != PSRPC_DONE
				&& (kind == PSRPC_KIND_HW || !aux_sel_125));
		end
	end
	// power modes; the 25 MHz enable stands in for the gated core clock
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			clock_multiplier_en <= 1'b0;
			aux_clock_out_en    <= 1'b0;
			mac_out_oe_n        <= 1'b1;
			mac_idle_force      <= 1'b1;
			line_enable         <= 1'b0;
			link_bringup        <= 1'b0;
			slow_clk_en         <= 1'b0;
			pd_q                <= 1'b0;
		end else begin
			pd_q                <= soft_powerdown;
			clock_multiplier_en <= !hw_pd
				&& (!soft_powerdown || aux_sel_125);
			aux_clock_out_en    <= aux_clock_enable && !hw_pd
				&& !(busy && (kind == PSRPC_KIND_PIN) && aux_sel_125)
				&& !(busy && kind == PSRPC_KIND_HW);
			mac_out_oe_n        <= hw_pd;
			mac_idle_force      <= hw_pd || soft_powerdown || core_rst;
			line_enable         <= !hw_pd && !soft_powerdown && !busy;
			link_bringup        <= !hw_pd && !busy && pd_q
				&& !soft_powerdown;
			slow_clk_en         <= tk.tick;
		end
	end
endmodule // psrpc_ctrl

// [dv/psrpc_host.sv]
// host model: register strobes toward the controller
`timescale 1ns/1ps
module psrpc_host (
	input  wire logic        ref_clk,
	input  wire logic        reg_ack,
	input  wire logic [15:0] reg_rdata,
	output logic             reg_wr,
	output logic             reg_rd,
	output logic      [15:0] reg_addr,
	output logic      [15:0] reg_wdata
);
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 16'h0000;
		reg_wdata = 16'h0000;
	end
	// retries while the controller is busy; a refused try shows no ack
	task automatic acc(input logic w, input logic [15:0] a, d,
		input int tries, output logic [15:0] q, output logic ok);
		ok = 1'b0;
		q = 16'h0000;
		for (int i = 0; i < tries && !ok; i++) begin
			@(posedge ref_clk);
			#2;
			reg_wr = w;
			reg_rd = !w;
			reg_addr = a;
			reg_wdata = d;
			@(posedge ref_clk);
			#2;
			reg_wr = 1'b0;
			reg_rd = 1'b0;
			// released lines carry junk, not the last value
			reg_addr = ~a;
			reg_wdata = ~d;
			if (reg_ack === 1'b1) begin
				ok = 1'b1;
				q = reg_rdata;
			end
		end
	endtask
endmodule // psrpc_host

// [dv/psrpc_ctrl_checker.sv]
// checker: port relations of the reset controller
`timescale 1ns/1ps
module psrpc_ctrl_checker (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic reset_n_pin,
	input wire logic aux_sel_125,
	input wire logic aux_clock_enable,
	input wire logic reg_ack,
	input wire logic xtal_enable,
	input wire logic subsys_regs_rst,
	input wire logic core_regs_rst,
	input wire logic mac_if_rst,
	input wire logic core_rst,
	input wire logic clock_multiplier_rst,
	input wire logic clock_multiplier_en,
	input wire logic aux_clock_out_en,
	input wire logic mac_out_oe_n,
	input wire logic mac_idle_force,
	input wire logic line_enable,
	input wire logic link_bringup,
	input wire logic soft_powerdown
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst);
	property p_hwpd_pins;
		!reset_n_pin |=> mac_out_oe_n && !aux_clock_out_en;
	endproperty
	a_hwpd_pins: assert property (p_hwpd_pins)
		else $error("mac outputs or aux clock live in power-down");
	property p_hwpd_noack;
		!reset_n_pin |=> !reg_ack;
	endproperty
	a_hwpd_noack: assert property (p_hwpd_noack)
		else $error("access answered in power-down");
	property p_sfpd_idle;
		soft_powerdown && reset_n_pin |-> ##[0:1] mac_idle_force;
	endproperty
	a_sfpd_idle: assert property (p_sfpd_idle)
		else $error("mac outputs not idle in soft power-down");
	property p_sfpd_line;
		soft_powerdown |-> ##[0:1] !line_enable;
	endproperty
	a_sfpd_line: assert property (p_sfpd_line)
		else $error("line active in soft power-down");
	property p_sfpd_mult;
		soft_powerdown && aux_sel_125 && reset_n_pin
			|-> ##[0:2] clock_multiplier_en;
	endproperty
	a_sfpd_mult: assert property (p_sfpd_mult)
		else $error("multiplier off in soft power-down");
	property p_wake;
		$fell(soft_powerdown) && reset_n_pin && !core_rst
			|-> ##[0:2] link_bringup;
	endproperty
	a_wake: assert property (p_wake)
		else $error("no link bring-up after soft power-down");
	property p_core_mac;
		core_regs_rst && !subsys_regs_rst |-> !mac_if_rst;
	endproperty
	a_core_mac: assert property (p_core_mac)
		else $error("mac block reset by core reset");
	property p_sw_mult;
		core_rst && !subsys_regs_rst && aux_sel_125 |-> !clock_multiplier_rst;
	endproperty
	a_sw_mult: assert property (p_sw_mult)
		else $error("multiplier reset with 125 MHz selected");
	property p_sw_aux;
		core_rst && !subsys_regs_rst && aux_clock_enable |-> aux_clock_out_en;
	endproperty
	a_sw_aux: assert property (p_sw_aux)
		else $error("aux clock stopped in core reset");
	property p_xtal;
		reset_n_pin |=> xtal_enable;
	endproperty
	a_xtal: assert property (p_xtal)
		else $error("oscillator gated while reset pin high");
endmodule // psrpc_ctrl_checker
bind psrpc_ctrl psrpc_ctrl_checker chk_u (.*);

// [dv/tb_phy_soft_reset_powerdown_ctrl.sv]
// testbench: reset kinds and power modes through register accesses
`timescale 1ns/1ps
module tb_phy_soft_reset_powerdown_ctrl;
	import psrpc_pkg::*;
	logic ref_clk = 1'b0, srst = 1'b1, reset_n_pin = 1'b1;
	logic [7:0] strap_pins = 8'h00, strap_latched;
	logic ls_pin = 1'b0, ind_pin = 1'b0, sel125 = 1'b1, aux_en = 1'b1;
	logic reg_wr, reg_rd, reg_ack, ok, oe_n, idle, line, wake, spd, aux_o;
	logic slow, xtal;
	logic [15:0] reg_addr, reg_wdata, reg_rdata, q;
	int err_count = 0, comparisons = 0, cyc = 0, n = 0;
	initial forever #12.5 ref_clk = ~ref_clk;
	psrpc_host host_u (.ref_clk(ref_clk), .reg_ack(reg_ack),
		.reg_rdata(reg_rdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata));
	psrpc_ctrl #(.SETTLE_CYCLES(10)) dut_u (.ref_clk(ref_clk), .srst(srst),
		.reset_n_pin(reset_n_pin), .strap_pins(strap_pins),
		.link_state_strap_pin(ls_pin), .indicator_strap_pin(ind_pin),
		.aux_sel_125(sel125), .aux_clock_enable(aux_en), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .reg_ack(reg_ack),
		.strap_latched(strap_latched), .xtal_enable(xtal), .subsys_regs_rst(),
		.core_regs_rst(), .mac_if_rst(), .core_rst(),
		.clock_multiplier_rst(), .clock_multiplier_en(),
		.aux_clock_out_en(aux_o), .mac_out_oe_n(oe_n),
		.mac_idle_force(idle), .line_enable(line), .link_bringup(wake),
		.slow_clk_en(slow), .soft_powerdown(spd));
	task automatic chk(string n, logic [15:0] seen, logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", n, exp, seen);
		end
	endtask
	task automatic wr(logic [15:0] a, logic [15:0] d);
		host_u.acc(1'b1, a, d, 100, q, ok);
		chk("write ack", ok, 1);
	endtask
	task automatic rd(string n, logic [15:0] a, logic [15:0] exp);
		host_u.acc(1'b0, a, 16'h0000, 100, q, ok);
		chk(n, q, exp);
	endtask
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			err_count++;
			summarize();
		end
	end
	initial begin
		repeat (2) @(posedge ref_clk);
		#2 srst = 1'b0;
		rd("core ctrl", CORE_CONTROL_ADDR, CORE_CONTROL_RST);
		rd("relatch en", PIN_RELATCH_EN_ADDR, 16'h0000);
		rd("unmapped", 16'h1234, 16'h0000);
		$display("test reset values done");
		wr(PIN_RELATCH_EN_ADDR, 16'h0001);
		wr(CORE_CONTROL_ADDR, 16'h0800);
		rd("soft pd", CORE_CONTROL_ADDR, 16'h0800);
		chk("idle", {idle, line, spd}, 3'b101);
		// 5 of 8 cycles, so any 16 in a row hold 10 pulses
		n = 0;
		repeat (16) begin
			@(posedge ref_clk);
			#2 n += slow;
		end
		chk("slow rate", n, 10);
		wr(CORE_CONTROL_ADDR, 16'h0000);
		@(posedge ref_clk);
		#2 chk("bringup", {wake, line, idle}, 3'b110);
		rd("woke", CORE_CONTROL_ADDR, 16'h0000);
		chk("bringup pulse", wake, 1'b0);
		wr(CORE_CONTROL_ADDR, 16'h0800);
		wr(CORE_CONTROL_ADDR, 16'h8000);
		rd("core rst", CORE_CONTROL_ADDR, 16'h0000);
		rd("sub kept", PIN_RELATCH_EN_ADDR, 16'h0001);
		$display("test power-down and core reset done");
		strap_pins = 8'h5A;
		wr(SUBSYS_RESET_ADDR, 16'h0001);
		@(posedge ref_clk);
		#2 chk("aux held", aux_o, 1'b0);
		rd("trigger", SUBSYS_RESET_ADDR, 16'h0000);
		rd("en cleared", PIN_RELATCH_EN_ADDR, 16'h0000);
		chk("relatched", strap_latched, 8'h5A);
		strap_pins = 8'h3C;
		sel125 = 1'b0;
		wr(SUBSYS_RESET_ADDR, 16'h0001);
		@(posedge ref_clk);
		#2 chk("aux kept", aux_o, 1'b1);
		rd("trigger2", SUBSYS_RESET_ADDR, 16'h0000);
		chk("kept straps", strap_latched, 8'h5A);
		$display("test subsystem resets done");
		@(posedge ref_clk);
		#2 reset_n_pin = 1'b0;
		repeat (5) @(posedge ref_clk);
		host_u.acc(1'b0, PIN_RELATCH_EN_ADDR, 16'h0000, 1, q, ok);
		chk("refused", ok, 0);
		chk("tristate", {oe_n, aux_o}, 2'b10);
		chk("xtal off", xtal, 1'b0);
		ls_pin = 1'b1;
		ind_pin = 1'b1;
		@(posedge ref_clk);
		#2 reset_n_pin = 1'b1;
		rd("after hw", PIN_RELATCH_EN_ADDR, 16'h0000);
		chk("hw straps", strap_latched, 8'h3C);
		rd("pd strap", CORE_CONTROL_ADDR, 16'h0800);
		ls_pin = 1'b0;
		wr(CORE_CONTROL_ADDR, 16'h0000);
		wr(SUBSYS_RESET_ADDR, 16'h0001);
		rd("pd kept", CORE_CONTROL_ADDR, 16'h0800);
		$display("test hardware power-down done");
		summarize();
	end
endmodule // tb_phy_soft_reset_powerdown_ctrl
